// ==== logic/async_serial_receiver.sv ====
// asynchronous serial receive path with two-entry fifo and apb registers
//
// Contract
// - recovery runs on a sixteen-times-baud tick; shift register advances per bit.
// - completed character moves at once into a hidden two-entry fifo.
// - reception only with receive enable, async mode and port enable set.
// - port enable forces the receive pin to input direction.
// - port enable forces transmit/clock pin to output, port latch disconnected.
// - a falling edge on the idle-high line starts a character.
// - half a bit later the start bit is rechecked; high aborts silently.
// - each following bit is voted at its centre and shifted in.
// - stop position sampled; low sets framing error, high clears it.
// - right after stop the character is pushed and the flag rises.
// - reading the data register returns and removes the oldest character.
// - receive flag is high while enabled and fifo holds a character.
// - interrupt only when receive, peripheral and global enables are set.
// - each fifo entry keeps its framing status; the head one is shown.
// - framing bit read-only; popping exposes the next entry's status.
// - framing error neither stops reception nor raises an interrupt.
// - clearing port enable resets the port; clearing receive enable keeps framing.
// - a third character arriving into a full fifo sets overrun.
// - in overrun stored data stays readable, nothing new; receive enable clears it.
// - nine-bit mode shifts nine data bits per character.
// - ninth-bit field shows bit eight of the head character.
//
// Implementation choices: the address map and the APB interface to the registers.
`include "serial_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module async_serial_receiver #(
	parameter int BAUD_W = 16
) (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        receive_pin_in,
	output logic             receive_pin_oe_out,
	output logic             transmit_clock_pin_oe_out,
	output logic             port_latch_connect_out,
	output logic             receive_interrupt_flag_out,
	output logic             irq_out
);

	typedef struct packed {
		logic [3:0]                 ctrl;
		logic [2:0]                 inten;
		logic [BAUD_W-1:0]          baud;
		serial_rx_pkg::rx_state_t   state;
		logic [3:0]                 tick_cnt;
		logic [3:0]                 bit_cnt;
		logic [8:0]                 shift;
		logic [2:0]                 votes;
		logic                       line_d;
		serial_rx_pkg::rx_entry_t   ent0;
		serial_rx_pkg::rx_entry_t   ent1;
		logic                       rd_ptr;
		logic [1:0]                 count;
		logic                       overrun;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic                       rx_oe;
		logic                       tx_oe;
		logic                       latch_conn;
		logic                       flag;
		logic                       irq;
	} rx_core_t;

	rx_core_t s_r;
	rx_core_t s_nxt;
	logic     tick;
	logic     port_en;
	logic     rx_run;

	// majority of three samples
	function automatic logic vote3(input logic [2:0] v);
		vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// head entry of the fifo
	function automatic serial_rx_pkg::rx_entry_t head_of(input rx_core_t s);
		head_of = s.rd_ptr ? s.ent1 : s.ent0;
	endfunction

	// data and stop votes land on the same tick of the bit
	function automatic logic vote_tick(input logic [3:0] c);
		vote_tick = (c == 4'h1);
	endfunction

	// tail slot of the two-entry fifo
	function automatic logic tail_of(input rx_core_t s);
		tail_of = s.rd_ptr ^ s.count[0];
	endfunction

	// port and receive enable, the sync bit aside
	function automatic logic rx_enabled(input logic [3:0] c);
		rx_enabled = c[`CTRL_PORT_EN_BIT] & c[`CTRL_RX_EN_BIT];
	endfunction

	// status word of the fifo head; entry fields read zero when empty
	function automatic logic [31:0] status_word(input rx_core_t s);
		serial_rx_pkg::rx_entry_t h;
		logic                     busy;
		h    = head_of(s);
		busy = (s.count != 2'h0);
		status_word = '0;
		status_word[`STAT_NINTH_BIT] = busy & h.data[8];
		status_word[`STAT_OVERRUN_BIT] = s.overrun;
		status_word[`STAT_FRAME_BIT] = busy & h.frame_err;
		status_word[`STAT_FLAG_BIT] = s.flag;
		status_word[`STAT_COUNT_LSB +: 2] = s.count;
	endfunction

	// =========================================================
	// enables
	assign port_en = s_r.ctrl[`CTRL_PORT_EN_BIT];
	// sync mode is not built here; selecting it parks the engine and clears overrun
	assign rx_run  = rx_enabled(s_r.ctrl)
		& ~s_r.ctrl[`CTRL_SYNC_BIT];

	// oversampling tick, divisor held in the baud register
	baud_tick_gen #(
		.DIV_W (BAUD_W)
	) u_tick (
		.clk_in     (clk_in),
		.rstn_in    (rstn_in),
		.run_in     (rx_run),
		.divisor_in (s_r.baud),
		.tick_out   (tick)
	);

	// =========================================================
	// next state
	always_comb begin
		serial_rx_pkg::rx_entry_t hd;
		serial_rx_pkg::rx_entry_t nw;
		logic                     push;
		logic                     pop;
		logic                     bit_v;
		logic [3:0]               nbits;
		hd     = head_of(s_r);
		nw     = '0;
		push   = 1'b0;
		pop    = 1'b0;
		bit_v  = 1'b0;
		nbits  = s_r.ctrl[`CTRL_NINE_BIT] ? 4'h9 : 4'h8;
		s_nxt  = s_r;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;

		// ---- receive engine, one step per oversampling tick
		if (tick) begin
			s_nxt.line_d = receive_pin_in;
			s_nxt.votes  = {s_r.votes[1:0], receive_pin_in};
			s_nxt.tick_cnt = s_r.tick_cnt + 4'h1;
			unique case (s_r.state)
				serial_rx_pkg::RX_IDLE: begin
					// edge from idle-high to low
					if (s_r.line_d && !receive_pin_in) begin
						s_nxt.state    = serial_rx_pkg::RX_START;
						s_nxt.tick_cnt = 4'h1;
					end
				end
				serial_rx_pkg::RX_START: begin
					if (s_r.tick_cnt == 4'(`HALF_BIT_TICKS)) begin
						// high at centre: abandon, no error
						if (receive_pin_in) begin
							s_nxt.state = serial_rx_pkg::RX_IDLE;
						end else begin
							s_nxt.state    = serial_rx_pkg::RX_DATA;
							// one tick on: the first vote lands a bit later
							s_nxt.tick_cnt = 4'h2;
							s_nxt.bit_cnt  = 4'h0;
							s_nxt.shift    = '0;
						end
					end
				end
				serial_rx_pkg::RX_DATA: begin
					// votes span ticks 15, 0 and 1 around the centre
					if (vote_tick(s_r.tick_cnt)) begin
						bit_v = vote3({s_r.votes[1:0],
							receive_pin_in});
						if (s_r.ctrl[`CTRL_NINE_BIT]) begin
							s_nxt.shift = {bit_v, s_r.shift[8:1]};
						end else begin
							s_nxt.shift = {1'b0, bit_v,
								s_r.shift[7:1]};
						end
						s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
						if (s_r.bit_cnt + 4'h1 == nbits) begin
							s_nxt.state = serial_rx_pkg::RX_STOP;
						end
					end
				end
				serial_rx_pkg::RX_STOP: begin
					if (vote_tick(s_r.tick_cnt)) begin
						// character finished; push unless overrun
						nw.data = s_r.shift;
						nw.frame_err = ~vote3({s_r.votes[1:0],
							receive_pin_in});
						s_nxt.state = serial_rx_pkg::RX_IDLE;
						if (s_r.count == 2'h2) begin
							s_nxt.overrun = 1'b1;
							s_nxt.state = serial_rx_pkg::RX_HOLD;
						end else begin
							push = 1'b1;
						end
						// a low stop does not halt reception
						s_nxt.line_d = 1'b0;
					end
				end
				serial_rx_pkg::RX_HOLD: begin
					// overrun: no new characters are taken
					s_nxt.state = serial_rx_pkg::RX_HOLD;
				end
				default: begin
					// unused code: back to the search for a start bit
					s_nxt.state = serial_rx_pkg::RX_IDLE;
				end
			endcase
		end

		// ---- apb slave, one wait state per access phase
		// writes commit as ready is raised; read data launches with it
		if (psel_in && penable_in && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
			unique case (paddr_in)
				`RX_CTRL_ADDR: begin
					if (pwrite_in) begin
						s_nxt.ctrl = pwdata_in[3:0];
					end
					s_nxt.prdata[3:0] = s_r.ctrl;
				end
				`RX_STATUS_ADDR: begin
					// flag bit is read-only: writes ignored
					s_nxt.prdata = status_word(s_r);
				end
				`RX_DATA_ADDR: begin
					s_nxt.prdata[7:0] = hd.data[7:0];
					// status first, this read advances the fifo
					if (!pwrite_in && s_r.count != 2'h0) begin
						pop = 1'b1;
					end
				end
				`RX_BAUD_ADDR: begin
					if (pwrite_in) begin
						s_nxt.baud = pwdata_in[BAUD_W-1:0];
					end
					s_nxt.prdata[BAUD_W-1:0] = s_r.baud;
				end
				`RX_INTEN_ADDR: begin
					if (pwrite_in) begin
						s_nxt.inten = pwdata_in[2:0];
					end
					s_nxt.prdata[2:0] = s_r.inten;
				end
				default: begin
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end

		// ---- fifo, two entries with read pointer and count
		// overrun is decided on the old count: a pop in that tick is late
		if (push) begin
			if (tail_of(s_r)) begin
				s_nxt.ent1 = nw;
			end else begin
				s_nxt.ent0 = nw;
			end
		end
		if (pop) begin
			s_nxt.rd_ptr = ~s_r.rd_ptr;
		end
		s_nxt.count = s_r.count + {1'b0, push} - {1'b0, pop};

		// ---- receive enable off: engine stops, overrun clears
		if (!rx_run) begin
			s_nxt.state    = serial_rx_pkg::RX_IDLE;
			s_nxt.line_d   = 1'b1;
			s_nxt.tick_cnt = 4'h0;
			s_nxt.votes    = 3'h7;
			s_nxt.overrun  = 1'b0;
		end

		// ---- port disable resets the fifo and its framing bits
		if (!port_en) begin
			s_nxt.ent0   = '0;
			s_nxt.ent1   = '0;
			s_nxt.count  = 2'h0;
			s_nxt.rd_ptr = 1'b0;
		end

		// ---- pin steering and interrupt outputs
		// the receive pin is never driven, whatever the port setting
		s_nxt.rx_oe      = 1'b0;
		s_nxt.tx_oe      = s_nxt.ctrl[`CTRL_PORT_EN_BIT];
		s_nxt.latch_conn = ~s_nxt.ctrl[`CTRL_PORT_EN_BIT];
		s_nxt.flag = rx_enabled(s_nxt.ctrl)
			& (s_nxt.count != 2'h0);
		s_nxt.irq = s_nxt.flag & s_nxt.inten[`INTEN_RX_BIT]
			& s_nxt.inten[`INTEN_PERIPH_BIT]
			& s_nxt.inten[`INTEN_GLOBAL_BIT];
	end

	// =========================================================
	// state register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_r          <= '0;
			s_r.ctrl     <= `CTRL_RESET;
			s_r.inten    <= `INTEN_RESET;
			s_r.baud     <= `BAUD_RESET;
			s_r.state    <= serial_rx_pkg::RX_IDLE;
			s_r.line_d   <= 1'b1;
			s_r.votes    <= 3'h7;
			s_r.latch_conn <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =========================================================
	// outputs, all from flip-flops
	assign prdata_out                 = s_r.prdata;
	assign pready_out                 = s_r.pready;
	assign pslverr_out                = s_r.pslverr;
	assign receive_pin_oe_out         = s_r.rx_oe;
	assign transmit_clock_pin_oe_out  = s_r.tx_oe;
	assign port_latch_connect_out     = s_r.latch_conn;
	assign receive_interrupt_flag_out = s_r.flag;
	assign irq_out                    = s_r.irq;

endmodule

`default_nettype wire

// ==== logic/baud_tick_gen.sv ====
// divider that makes the sixteen-times-baud sampling tick
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             run_in,
	input  wire logic [DIV_W-1:0] divisor_in,
	output logic                  tick_out
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} tick_state_t;

	tick_state_t s_r;
	tick_state_t s_nxt;

	// =========================================================
	// divider
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!run_in) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt >= divisor_in) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + DIV_W'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_out = s_r.tick;

endmodule

`default_nettype wire

// ==== logic/serial_rx_pkg.sv ====
// types shared by the serial receiver
package serial_rx_pkg;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b011,
		RX_STOP  = 3'b010,
		RX_HOLD  = 3'b110
	} rx_state_t;

	typedef struct packed {
		logic [8:0] data;
		logic       frame_err;
	} rx_entry_t;

endpackage

// ==== logic/serial_rx_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH

// byte addresses on the apb bus
`define RX_CTRL_ADDR        12'h000
`define RX_STATUS_ADDR      12'h004
`define RX_DATA_ADDR        12'h008
`define RX_BAUD_ADDR        12'h00C
`define RX_INTEN_ADDR       12'h010

// control register fields
`define CTRL_PORT_EN_BIT    0
`define CTRL_RX_EN_BIT      1
`define CTRL_SYNC_BIT       2
`define CTRL_NINE_BIT       3

// status register fields
`define STAT_NINTH_BIT      0
`define STAT_OVERRUN_BIT    1
`define STAT_FRAME_BIT      2
`define STAT_FLAG_BIT       3
`define STAT_COUNT_LSB      4

// interrupt enable register fields
`define INTEN_RX_BIT        0
`define INTEN_PERIPH_BIT    1
`define INTEN_GLOBAL_BIT    2

// reset values
`define CTRL_RESET          4'h0
`define INTEN_RESET         3'h0
`define BAUD_RESET          16'h0000

// oversampling figures
`define OVERSAMPLE          16
`define HALF_BIT_TICKS      8
`define VOTE_FIRST_TICK     7

`endif

// ==== verification/rx_properties.sv ====
// port-level assertions for the serial receiver
`include "serial_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_props (
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        receive_pin_oe_out,
	input wire logic        transmit_clock_pin_oe_out,
	input wire logic        port_latch_connect_out,
	input wire logic        receive_interrupt_flag_out,
	input wire logic        irq_out
);
	// ====================
	// helpers
	// only a data read or a control write may lower flag or change pin drive
	wire logic hit;
	assign hit = psel_in && (paddr_in == `RX_DATA_ADDR && !pwrite_in
		|| paddr_in == `RX_CTRL_ADDR && pwrite_in);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ====================
	// assertions
	rx_input_a: assert property (!receive_pin_oe_out)
		else $error("receive pin driven");
	latch_cut_a: assert property (
		port_latch_connect_out != transmit_clock_pin_oe_out)
		else $error("latch and pin drive agree");
	oe_write_a: assert property ($changed(transmit_clock_pin_oe_out)
		|-> $past(hit) || $past(hit, 2) || $past(hit, 3))
		else $error("pin drive changed without write");
	flag_port_a: assert property (
		receive_interrupt_flag_out |-> transmit_clock_pin_oe_out)
		else $error("flag with port off");
	irq_gate_a: assert property (irq_out |-> receive_interrupt_flag_out)
		else $error("irq without flag");
	flag_drop_a: assert property ($fell(receive_interrupt_flag_out)
		|-> $past(hit) || $past(hit, 2) || $past(hit, 3))
		else $error("flag fell without read");
	ready_wait_a: assert property (
		psel_in && penable_in && !pready_out |=> pready_out)
		else $error("no ready after one wait");
	ready_pulse_a: assert property (pready_out |=> !pready_out)
		else $error("ready longer than a cycle");
	err_addr_a: assert property (pready_out |->
		pslverr_out == (paddr_in > `RX_INTEN_ADDR))
		else $error("slave error wrong");
	cover property ($rose(receive_interrupt_flag_out));
	cover property (irq_out);
	cover property (pready_out && pslverr_out);
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the serial receiver
`include "serial_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; \
	if ((e) !== (s)) begin fails++; \
	$display("BAD %s exp %h seen %h", n, e, s); end end

module tb;
	localparam int BAUD = 1;
	logic        clk_in, rstn_in, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, perr, rx_oe, tx_oe, latch, flag, irq;
	wire  logic  line;
	int          fails = 0;
	int          num_checks = 0;
	async_serial_receiver i_async_serial_receiver (
		.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .receive_pin_in(line),
		.receive_pin_oe_out(rx_oe), .transmit_clock_pin_oe_out(tx_oe),
		.port_latch_connect_out(latch),
		.receive_interrupt_flag_out(flag), .irq_out(irq));
	tx_model #(.BIT_CLKS((BAUD + 1) * 16)) i_tx_model (
		.clk_in(clk_in), .line_out(line));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	initial begin
		#100000;
		fails++;
		final_report();
	end
	// ====================
	// bus tasks
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_in);
			n++;
		end
		if (pready !== 1'b1) begin
			fails++;
			$display("BAD pready exp 1 seen %b", pready);
		end
		rdat = prdata;
		er = perr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic w(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rdat)
	endtask
	function automatic logic [31:0] st(input int c, f, e, o, n);
		return 32'(c * 16 + f * 8 + e * 4 + o * 2 + n);
	endfunction
	// ====================
	// scenarios
	task automatic t_reset();
		`CHK("latch", 1'b1, latch)
		`CHK("rx_oe", 1'b0, rx_oe)
		rc("ctrl", `RX_CTRL_ADDR, 32'h0000_0000);
		apb(1'b0, 12'h020, 32'h0000_0000);
		`CHK("slverr", 1'b1, er)
	endtask
	task automatic t_enable();
		w(`RX_BAUD_ADDR, BAUD);
		w(`RX_INTEN_ADDR, 32'h0000_0007);
		w(`RX_CTRL_ADDR, 32'h0000_0003);
		repeat (2) @(posedge clk_in);
		`CHK("tx_oe", 1'b1, tx_oe)
		`CHK("latch", 1'b0, latch)
		`CHK("rx_oe", 1'b0, rx_oe)
	endtask
	task automatic t_frame();
		i_tx_model.send(9'h03C, 8, 1'b0);
		i_tx_model.send(9'h0A5, 8, 1'b1);
		`CHK("irq", 1'b1, irq)
		rc("st", `RX_STATUS_ADDR, st(2, 1, 1, 0, 0));
		rc("dat", `RX_DATA_ADDR, 32'h0000_003C);
		w(`RX_STATUS_ADDR, 32'h0000_0000);
		rc("st", `RX_STATUS_ADDR, st(1, 1, 0, 0, 0));
		rc("dat", `RX_DATA_ADDR, 32'h0000_00A5);
		repeat (3) @(posedge clk_in);
		`CHK("flag", 1'b0, flag)
	endtask
	task automatic t_overrun();
		for (int i = 0; i < 3; i++)
			i_tx_model.send(9'h081 + 9'(i), 8, 1'b0);
		i_tx_model.send(9'h084, 8, 1'b1);
		rc("st", `RX_STATUS_ADDR, st(2, 1, 1, 1, 0));
		rc("dat", `RX_DATA_ADDR, 32'h0000_0081);
		rc("st", `RX_STATUS_ADDR, st(1, 1, 1, 1, 0));
		rc("dat", `RX_DATA_ADDR, 32'h0000_0082);
		w(`RX_CTRL_ADDR, 32'h0000_0001);
		w(`RX_CTRL_ADDR, 32'h0000_0003);
		rc("st", `RX_STATUS_ADDR, st(0, 0, 0, 0, 0));
	endtask
	task automatic t_keep();
		i_tx_model.send(9'h00F, 8, 1'b0);
		w(`RX_CTRL_ADDR, 32'h0000_0001);
		rc("st", `RX_STATUS_ADDR, st(1, 0, 1, 0, 0));
		w(`RX_CTRL_ADDR, 32'h0000_0000);
		rc("st", `RX_STATUS_ADDR, st(0, 0, 0, 0, 0));
		`CHK("latch", 1'b1, latch)
	endtask
	task automatic t_glitch();
		w(`RX_CTRL_ADDR, 32'h0000_0007);
		i_tx_model.send(9'h011, 8, 1'b1);
		`CHK("flag", 1'b0, flag)
		w(`RX_CTRL_ADDR, 32'h0000_0003);
		i_tx_model.glitch();
		`CHK("flag", 1'b0, flag)
		i_tx_model.send(9'h066, 8, 1'b1);
		rc("dat", `RX_DATA_ADDR, 32'h0000_0066);
	endtask
	task automatic t_nine();
		w(`RX_CTRL_ADDR, 32'h0000_000B);
		i_tx_model.send(9'h15A, 9, 1'b1);
		w(`RX_INTEN_ADDR, 32'h0000_0003);
		repeat (2) @(posedge clk_in);
		`CHK("irq", 1'b0, irq)
		rc("st", `RX_STATUS_ADDR, st(1, 1, 0, 0, 1));
		apb(1'b0, `RX_DATA_ADDR, 32'h0000_0000);
		`CHK("dat", 8'h5A, rdat[7:0])
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		rstn_in = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_enable();
		t_frame();
		t_overrun();
		t_keep();
		t_glitch();
		t_nine();
		final_report();
	end
endmodule

bind async_serial_receiver rx_props i_rx_props (
	.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out),
	.receive_pin_oe_out(receive_pin_oe_out),
	.transmit_clock_pin_oe_out(transmit_clock_pin_oe_out),
	.port_latch_connect_out(port_latch_connect_out),
	.receive_interrupt_flag_out(receive_interrupt_flag_out),
	.irq_out(irq_out));

`default_nettype wire

// ==== verification/tx_model.sv ====
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none

module tx_model #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic clk_in,
	output var logic  line_out
);
	initial line_out = 1'b1;
	// ====================
	// frames, lsb first
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		line_out <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (BIT_CLKS) @(posedge clk_in);
		end
		line_out <= stop;
		repeat (BIT_CLKS) @(posedge clk_in);
		line_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
	// low pulse well short of half a bit
	task automatic glitch();
		line_out <= 1'b0;
		repeat (BIT_CLKS / 4) @(posedge clk_in);
		line_out <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk_in);
	endtask
endmodule

`default_nettype wire
